// >>> include/smcc_cfg.svh
// constants for the shunt monitor conversion control block
`ifndef SMCC_CFG_SVH
`define SMCC_CFG_SVH
// =====================================================================
// configuration word layout and power-up values
`define SMCC_CFG_RST_BIT 15
`define SMCC_CFG_BRNG_BIT 13
`define SMCC_CFG_PGA_HI 12
`define SMCC_CFG_PGA_LO 11
`define SMCC_CFG_BUS_AVG_RES_FIELD_HI 10
`define SMCC_CFG_BUS_AVG_RES_FIELD_LO 7
`define SMCC_CFG_SHUNT_AVG_RES_FIELD_HI 6
`define SMCC_CFG_SHUNT_AVG_RES_FIELD_LO 3
`define SMCC_CFG_MODE_HI 2
`define SMCC_CFG_MODE_LO 0
`define SMCC_CFG_RESET_VAL 16'h399f
`define SMCC_CAL_RESET_VAL 16'h0000
// =====================================================================
// operating mode codes
`define SMCC_MODE_PD 3'h0
`define SMCC_MODE_SH_TRIG 3'h1
`define SMCC_MODE_BUS_TRIG 3'h2
`define SMCC_MODE_BOTH_TRIG 3'h3
`define SMCC_MODE_OFF 3'h4
`define SMCC_MODE_BOTH_CONT 3'h7
// =====================================================================
// timing: clock in kHz, times in ns
`define SMCC_CLK_KHZ 25000
`define SMCC_TRIG_MIN_NS 4000
`define SMCC_PD_RECOVER_NS 40000
`define SMCC_TRIG_CYC ((`SMCC_TRIG_MIN_NS * `SMCC_CLK_KHZ + 999999) / 1000000)
`define SMCC_REC_CYC ((`SMCC_PD_RECOVER_NS * `SMCC_CLK_KHZ + 999999) / 1000000)
// =====================================================================
// scaling
`define SMCC_SH_FS_BASE 4000
`define SMCC_BUS_FS_16V 4000
`define SMCC_BUS_FS_32V 8000
`define SMCC_CUR_SHIFT 12
`define SMCC_PWR_DIV 5000
`define SMCC_CUR_MAX 32767
`endif

// >>> include/smcc_pkg.sv
// types for the shunt monitor conversion control block
package smcc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SH_REQ,
        ST_SH_WAIT,
        ST_BUS_REQ,
        ST_BUS_WAIT,
        ST_MATH,
        ST_MWAIT
    } smcc_state_t;
    typedef logic [2:0] smcc_mode_t;
endpackage : smcc_pkg

// >>> logic/smcc_math.sv
// current and power scaling engine
`timescale 1ns/1ns
`include "smcc_cfg.svh"
module smcc_math (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // request
    input wire logic start,
    input wire logic clear,
    input wire logic [15:0] shunt,
    input wire logic [12:0] bus,
    input wire logic [15:0] cal,
    // results
    output logic [15:0] current,
    output logic [15:0] power,
    output logic done
);
    logic [15:0] cur_q, cur_d, pwr_q, pwr_d;
    logic done_q, done_d;
    logic signed [33:0] prod;
    logic signed [33:0] scaled;
    logic signed [15:0] cur_w;
    logic [15:0] mag;
    logic [28:0] pprod;
    logic [28:0] pquot;

    // =================================================================
    // scaling
    always_comb begin
        prod = $signed({{18{shunt[15]}}, shunt}) * $signed({18'h00000, cal});
        scaled = prod >>> `SMCC_CUR_SHIFT;
        // saturate at the largest positive code and its mirror
        if (scaled > 34'sd32767) begin
            cur_w = 16'sd32767;
        end else if (scaled < -34'sd32767) begin
            cur_w = -16'sd32767;
        end else begin
            cur_w = scaled[15:0];
        end
        mag = cur_w[15] ? 16'(-cur_w) : cur_w;
        // bus code weight is fixed, so power lsb is twenty current lsbs
        pprod = 29'(mag * bus);
        pquot = pprod / 29'(`SMCC_PWR_DIV);
        cur_d = cur_q;
        pwr_d = pwr_q;
        done_d = 1'b0;
        if (clear) begin
            cur_d = 16'h0000;
            pwr_d = 16'h0000;
        end else if (start) begin
            // an unprogrammed calibration yields zero results
            cur_d = cur_w;
            pwr_d = (pquot > 29'h000ffff) ? 16'hffff : pquot[15:0];
            done_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cur_q <= 16'h0000;
            pwr_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            cur_q <= cur_d;
            pwr_q <= pwr_d;
            done_q <= done_d;
        end
    end

    assign current = cur_q;
    assign power = pwr_q;
    assign done = done_q;

    // =================================================================
    // checks
    a_cal_zero_out: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (start && !clear && cal == 16'h0000) |=> (current == 16'h0000 && done))
        else $error("uncalibrated current not zero");
endmodule : smcc_math

// >>> logic/smcc_core.sv
// conversion sequencing, trigger, ready flag and results
// =====================================================================
// How it works
// - continuous mode repeats shunt conversions per averaging
// - then bus conversions per bus averaging
// - modes: shunt/bus only, continuous or triggered
// - current and power computed in background
// - power-down cuts input current; wait recovery
// - converter-off mode halts all conversion
// - convert pin low for minimum starts conversion
// - convert pin ignored while conversion runs
// - triggered conversions also honour averaging counts
// - triggered mode write with pin low fires
// - results hold until next completed conversion
// - ready flag set after math completes
// - ready clears: config write except to power-down or off, status read, pin
// - shunt gain selects one to eight range
// - bus range selectable sixteen or thirty-two volts
// - power-up defaults: widest gain, continuous both
// - current and power need programmed calibration
// - all registers volatile, defaults at power-up
// - fixed bus lsb; power lsb twenty current
// - current result saturates at largest code
// - shunt and bus sampled at different times
// - software or general call reset restores defaults
`timescale 1ns/1ns
`include "smcc_cfg.svh"
module smcc_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register access from the serial slave
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic cal_wr,
    input wire logic [15:0] cal_wdata,
    input wire logic stat_rd,
    input wire logic gen_call_rst,
    // convert pin, active low, asynchronous
    input wire logic convert_n,
    // converter handshake
    input wire logic adc_done,
    input wire logic [15:0] adc_code,
    output logic adc_start,
    output logic adc_sel_bus,
    // analog front end control
    output logic sense_enable,
    output logic [1:0] shunt_gain_sel,
    output logic bus_range_32v,
    output logic meas_ready,
    // register contents
    output logic [15:0] cfg_value,
    output logic [15:0] cal_value,
    output logic [15:0] shunt_result,
    output logic [12:0] bus_result,
    output logic [15:0] current_result,
    output logic [15:0] power_result,
    output logic conversion_ready_flag
);
    localparam logic [6:0] TRIG_LAST = 7'(`SMCC_TRIG_CYC - 1);
    localparam logic [9:0] REC_CYC = 10'(`SMCC_REC_CYC);

    logic [15:0] cfg_q, cfg_d, cal_q, cal_d;
    logic conv_s1_q, conv_s2_q, armed_q, armed_d;
    logic [6:0] low_cnt_q, low_cnt_d;
    logic [9:0] rec_q, rec_d;
    smcc_pkg::smcc_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic signed [22:0] acc_q, acc_d;
    logic [15:0] shunt_q, shunt_d;
    logic [12:0] bus_q, bus_d;
    logic pend_q, pend_d, flag_q, flag_d;
    smcc_pkg::smcc_mode_t mode, new_mode;
    logic soft_rst, halt, cont, trig_mode, busy, pin_fire, wr_fire;
    logic cfg_clr, set_flag, math_go, math_done;
    logic [3:0] fld;
    logic [7:0] last_w;
    logic [2:0] shift_w;
    logic signed [22:0] sum_w, avg_w, lim_w;

    // =================================================================
    // configuration and calibration
    assign mode = cfg_q[`SMCC_CFG_MODE_HI:`SMCC_CFG_MODE_LO];
    assign new_mode = cfg_wdata[`SMCC_CFG_MODE_HI:`SMCC_CFG_MODE_LO];
    assign soft_rst = gen_call_rst | (cfg_wr & cfg_wdata[`SMCC_CFG_RST_BIT]);

    always_comb begin
        cfg_d = cfg_q;
        cal_d = cal_q;
        if (soft_rst) begin
            cfg_d = `SMCC_CFG_RESET_VAL;
            cal_d = `SMCC_CAL_RESET_VAL;
        end else begin
            if (cfg_wr) begin
                cfg_d = cfg_wdata;
            end
            if (cal_wr) begin
                cal_d = cal_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // defaults: 12-bit, 320 mV gain, 32 V range, both continuous
            cfg_q <= `SMCC_CFG_RESET_VAL;
            cal_q <= `SMCC_CAL_RESET_VAL;
        end else begin
            cfg_q <= cfg_d;
            cal_q <= cal_d;
        end
    end

    assign halt = (mode == `SMCC_MODE_PD) || (mode == `SMCC_MODE_OFF);
    assign cont = mode[2] && (mode[1:0] != 2'b00);
    assign trig_mode = !mode[2] && (mode[1:0] != 2'b00);
    assign cfg_clr = cfg_wr && !soft_rst && (new_mode != `SMCC_MODE_PD)
        && (new_mode != `SMCC_MODE_OFF);
    assign wr_fire = cfg_wr && !soft_rst && !new_mode[2] && (new_mode[1:0] != 2'b00)
        && !conv_s2_q;

    // =================================================================
    // convert pin: two-stage synchroniser and low-time qualifier
    assign busy = (state_q != smcc_pkg::ST_IDLE) || pend_q;
    assign pin_fire = trig_mode && !busy && armed_q && !conv_s2_q
        && (low_cnt_q == TRIG_LAST);

    always_comb begin
        low_cnt_d = low_cnt_q;
        armed_d = armed_q;
        // the pin must be seen high after a conversion before it re-arms,
        // so a low held through a whole conversion cannot fire twice
        if (busy || conv_s2_q || !armed_q) begin
            low_cnt_d = 7'h00;
        end else if (low_cnt_q != TRIG_LAST) begin
            low_cnt_d = low_cnt_q + 7'h01;
        end
        if (busy) begin
            armed_d = 1'b0;
        end else if (conv_s2_q) begin
            armed_d = 1'b1;
        end else if (pin_fire) begin
            armed_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            conv_s1_q <= 1'b1;
            conv_s2_q <= 1'b1;
            armed_q <= 1'b0;
            low_cnt_q <= 7'h00;
        end else begin
            conv_s1_q <= convert_n;
            conv_s2_q <= conv_s1_q;
            armed_q <= armed_d;
            low_cnt_q <= low_cnt_d;
        end
    end

    // =================================================================
    // power-down recovery
    always_comb begin
        if (mode == `SMCC_MODE_PD) begin
            rec_d = REC_CYC;
        end else if (rec_q != 10'h000) begin
            rec_d = rec_q - 10'h001;
        end else begin
            rec_d = rec_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rec_q <= 10'h000;
        end else begin
            rec_q <= rec_d;
        end
    end

    assign meas_ready = (rec_q == 10'h000) && (mode != `SMCC_MODE_PD);
    assign sense_enable = (mode != `SMCC_MODE_PD);
    assign shunt_gain_sel = cfg_q[`SMCC_CFG_PGA_HI:`SMCC_CFG_PGA_LO];
    assign bus_range_32v = cfg_q[`SMCC_CFG_BRNG_BIT];

    // =================================================================
    // sequencer, averaging and result registers
    always_comb begin
        fld = (state_q == smcc_pkg::ST_SH_WAIT)
            ? cfg_q[`SMCC_CFG_SHUNT_AVG_RES_FIELD_HI:`SMCC_CFG_SHUNT_AVG_RES_FIELD_LO]
            : cfg_q[`SMCC_CFG_BUS_AVG_RES_FIELD_HI:`SMCC_CFG_BUS_AVG_RES_FIELD_LO];
        // averaging codes take 2**n samples; resolution codes take one
        last_w = fld[3] ? 8'((9'h001 << fld[2:0]) - 9'h001) : 8'h00;
        shift_w = fld[3] ? fld[2:0] : 3'h0;
        sum_w = acc_q + {{7{adc_code[15]}}, adc_code};
        avg_w = sum_w >>> shift_w;
        if (state_q == smcc_pkg::ST_SH_WAIT) begin
            lim_w = 23'(`SMCC_SH_FS_BASE) << shunt_gain_sel;
        end else if (bus_range_32v) begin
            lim_w = 23'(`SMCC_BUS_FS_32V);
        end else begin
            lim_w = 23'(`SMCC_BUS_FS_16V);
        end
        state_d = state_q;
        cnt_d = cnt_q;
        acc_d = acc_q;
        shunt_d = shunt_q;
        bus_d = bus_q;
        pend_d = pend_q;
        adc_start = 1'b0;
        math_go = 1'b0;
        set_flag = 1'b0;
        unique case (state_q)
            smcc_pkg::ST_IDLE: begin
                if ((pend_q || cont) && meas_ready && !halt) begin
                    pend_d = 1'b0;
                    cnt_d = 8'h00;
                    acc_d = 23'sd0;
                    state_d = mode[0] ? smcc_pkg::ST_SH_REQ : smcc_pkg::ST_BUS_REQ;
                end
            end
            smcc_pkg::ST_SH_REQ: begin
                adc_start = 1'b1;
                state_d = smcc_pkg::ST_SH_WAIT;
            end
            smcc_pkg::ST_SH_WAIT: begin
                if (adc_done) begin
                    acc_d = sum_w;
                    cnt_d = cnt_q + 8'h01;
                    state_d = smcc_pkg::ST_SH_REQ;
                    if (cnt_q == last_w) begin
                        // result only replaced once the full average is in
                        if (avg_w > lim_w) begin
                            shunt_d = lim_w[15:0];
                        end else if (avg_w < -lim_w) begin
                            shunt_d = 16'(-lim_w);
                        end else begin
                            shunt_d = avg_w[15:0];
                        end
                        cnt_d = 8'h00;
                        acc_d = 23'sd0;
                        // bus is sampled only after all shunt samples
                        state_d = mode[1] ? smcc_pkg::ST_BUS_REQ : smcc_pkg::ST_MATH;
                    end
                end
            end
            smcc_pkg::ST_BUS_REQ: begin
                adc_start = 1'b1;
                state_d = smcc_pkg::ST_BUS_WAIT;
            end
            smcc_pkg::ST_BUS_WAIT: begin
                if (adc_done) begin
                    acc_d = sum_w;
                    cnt_d = cnt_q + 8'h01;
                    state_d = smcc_pkg::ST_BUS_REQ;
                    if (cnt_q == last_w) begin
                        if (avg_w > lim_w) begin
                            bus_d = lim_w[12:0];
                        end else if (avg_w < 23'sd0) begin
                            bus_d = 13'h0000;
                        end else begin
                            bus_d = avg_w[12:0];
                        end
                        cnt_d = 8'h00;
                        acc_d = 23'sd0;
                        state_d = smcc_pkg::ST_MATH;
                    end
                end
            end
            smcc_pkg::ST_MATH: begin
                // scaling runs after sampling ends, costing no converter time
                math_go = 1'b1;
                state_d = smcc_pkg::ST_MWAIT;
            end
            smcc_pkg::ST_MWAIT: begin
                if (math_done) begin
                    set_flag = 1'b1;
                    state_d = smcc_pkg::ST_IDLE;
                end
            end
        endcase
        if (cfg_wr || halt) begin
            state_d = smcc_pkg::ST_IDLE;
            pend_d = 1'b0;
        end
        if (pin_fire || wr_fire) begin
            pend_d = 1'b1;
        end
        if (soft_rst) begin
            state_d = smcc_pkg::ST_IDLE;
            pend_d = 1'b0;
            shunt_d = 16'h0000;
            bus_d = 13'h0000;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= smcc_pkg::ST_IDLE;
            cnt_q <= 8'h00;
            acc_q <= 23'sd0;
            shunt_q <= 16'h0000;
            bus_q <= 13'h0000;
            pend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            shunt_q <= shunt_d;
            bus_q <= bus_d;
            pend_q <= pend_d;
        end
    end

    assign adc_sel_bus = (state_q == smcc_pkg::ST_BUS_REQ);

    // =================================================================
    // conversion ready flag: a set in the clearing cycle wins, except over soft reset
    always_comb begin
        if (soft_rst) begin
            flag_d = 1'b0;
        end else if (set_flag) begin
            flag_d = 1'b1;
        end else if (stat_rd || cfg_clr || pin_fire) begin
            flag_d = 1'b0;
        end else begin
            flag_d = flag_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    smcc_math u_math (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(math_go),
        .clear(soft_rst),
        .shunt(shunt_q),
        .bus(bus_q),
        .cal(cal_q),
        .current(current_result),
        .power(power_result),
        .done(math_done)
    );

    assign cfg_value = cfg_q;
    assign cal_value = cal_q;
    assign shunt_result = shunt_q;
    assign bus_result = bus_q;
    assign conversion_ready_flag = flag_q;

    // =================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_halt_stops: assert property (halt && !pend_q |=> !adc_start)
        else $error("conversion while halted");
    a_pd_sense_off: assert property (!sense_enable |-> state_q == smcc_pkg::ST_IDLE)
        else $error("inputs sensed in power-down");
    a_recover_hold: assert property (rec_q != 10'h000 |-> !adc_start)
        else $error("conversion before recovery");
    a_pin_ignored: assert property (busy |=> !armed_q && low_cnt_q == 7'h00)
        else $error("pin fired while busy");
    a_pin_starts: assert property (pin_fire && !soft_rst |=> pend_q && !flag_q)
        else $error("pin trigger lost");
    a_wr_trigger: assert property (wr_fire |=> pend_q)
        else $error("write trigger lost");
    a_bus_after: assert property (state_q == smcc_pkg::ST_SH_WAIT && adc_done
        && cnt_q == last_w && mode[1] && !cfg_wr && !halt && !soft_rst
        |=> state_q == smcc_pkg::ST_BUS_REQ)
        else $error("bus not after shunt");
    a_shunt_hold: assert property (!(state_q == smcc_pkg::ST_SH_WAIT && adc_done)
        && !soft_rst |=> $stable(shunt_result))
        else $error("shunt result changed early");
    a_flag_set: assert property ($rose(conversion_ready_flag)
        |-> $past(math_done) && $past(state_q) == smcc_pkg::ST_MWAIT)
        else $error("ready set before math done");
    a_flag_clear: assert property ((stat_rd || cfg_clr) && !set_flag
        |=> !conversion_ready_flag)
        else $error("ready flag not cleared");
    a_soft_reset: assert property (soft_rst
        |=> cfg_value == `SMCC_CFG_RESET_VAL && cal_value == `SMCC_CAL_RESET_VAL)
        else $error("soft reset left settings");

    c_cont_cycle: cover property (mode == `SMCC_MODE_BOTH_CONT && set_flag);
    c_pin_trig: cover property (pin_fire ##[1:1000] set_flag);
    c_wr_trig: cover property (wr_fire ##[1:1000] set_flag);
    c_pd_exit: cover property ($fell(mode == `SMCC_MODE_PD) ##[1:1000] meas_ready);
endmodule : smcc_core

// >>> testbench/smcc_adc_model.sv
// converter model answering sample requests after a programmable latency
`timescale 1ns/1ns
module smcc_adc_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // sample handshake
    input wire logic adc_start,
    input wire logic adc_sel_bus,
    output logic adc_done,
    output logic [15:0] adc_code,
    // stimulus set by the bench
    input wire logic [7:0] lat,
    input wire logic [15:0] sh_code,
    input wire logic [15:0] bus_code
);
    logic [7:0] cnt;
    logic sel;
    logic busy;
    // =====================================================================
    // one answer per request; the code is not left showing between answers
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            adc_done <= 1'b0;
            adc_code <= 16'h5a5a;
        end else begin
            adc_done <= 1'b0;
            if (adc_done) begin
                adc_code <= ~adc_code;
            end
            if (adc_start) begin
                busy <= 1'b1;
                cnt <= lat;
                sel <= adc_sel_bus;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                adc_done <= 1'b1;
                adc_code <= sel ? bus_code : sh_code;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : smcc_adc_model

// >>> testbench/test_shunt_monitor_conversion_control.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ns
module test_shunt_monitor_conversion_control;
    logic clk_sys = 1'b0;
    logic arst_n, cfg_wr, cal_wr, stat_rd, gen_call_rst, convert_n, adc_done, adc_start;
    logic adc_sel_bus, sense_enable, bus_range_32v, meas_ready, conversion_ready_flag;
    logic [15:0] cfg_wdata, cal_wdata, sh, bsc, adc_code, cfg_value, cal_value;
    logic [15:0] shunt_result, current_result, power_result;
    logic [12:0] bus_result;
    logic [7:0] lat;
    logic [1:0] shunt_gain_sel;
    int n_fail = 0;
    int checks_done = 0;
    int n_sh = 0;
    int n_bus = 0;
    always #20 clk_sys = ~clk_sys;
    smcc_core dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cal_wr(cal_wr), .cal_wdata(cal_wdata), .stat_rd(stat_rd), .gen_call_rst(gen_call_rst),
        .convert_n(convert_n), .adc_done(adc_done), .adc_code(adc_code), .adc_start(adc_start),
        .adc_sel_bus(adc_sel_bus), .sense_enable(sense_enable), .shunt_gain_sel(shunt_gain_sel),
        .bus_range_32v(bus_range_32v), .meas_ready(meas_ready), .cfg_value(cfg_value),
        .cal_value(cal_value), .shunt_result(shunt_result), .bus_result(bus_result),
        .current_result(current_result), .power_result(power_result),
        .conversion_ready_flag(conversion_ready_flag));
    smcc_adc_model adc_u (.clk_sys(clk_sys), .arst_n(arst_n), .adc_start(adc_start),
        .adc_sel_bus(adc_sel_bus), .adc_done(adc_done), .adc_code(adc_code), .lat(lat),
        .sh_code(sh), .bus_code(bsc));
    // =====================================================================
    // sample requests counted mid-cycle, where the strobe has settled
    always @(negedge clk_sys) begin
        if (adc_start === 1'b1 && adc_sel_bus === 1'b1) n_bus++;
        else if (adc_start === 1'b1) n_sh++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic wcfg(input logic [15:0] v);
        cfg_wr = 1'b1;
        cfg_wdata = v;
        cyc(1);
        cfg_wr = 1'b0;
    endtask : wcfg
    task automatic wcal(input logic [15:0] v);
        cal_wr = 1'b1;
        cal_wdata = v;
        cyc(1);
        cal_wr = 1'b0;
    endtask : wcal
    task automatic srd();
        stat_rd = 1'b1;
        cyc(1);
        stat_rd = 1'b0;
    endtask : srd
    task automatic wait_flag();
        for (int i = 0; i < 3000 && conversion_ready_flag !== 1'b1; i++) cyc(1);
        check(conversion_ready_flag, 16'h0001);
    endtask : wait_flag
    // two rounds so that no result computed with the old settings remains
    task automatic settle();
        srd();
        wait_flag();
        srd();
        wait_flag();
    endtask : settle
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // =====================================================================
    // watchdog: the tests need well under 5000 cycles
    initial begin
        #(40 * 20000);
        n_fail++;
        test_done();
    end
    initial begin
        logic [2:0] m;
        {arst_n, cfg_wr, cal_wr, stat_rd, gen_call_rst} = 5'h00;
        {cfg_wdata, cal_wdata} = 32'h0;
        convert_n = 1'b1;
        lat = 8'h02;
        sh = 16'd1000;
        bsc = 16'd2500;
        cyc(4);
        arst_n = 1'b1;
        check(cfg_value, 16'h399f);
        check(cal_value, 16'h0000);
        check({14'h0, shunt_gain_sel}, 16'h0003);
        check({15'h0, bus_range_32v}, 16'h0001);
        $display("test defaults done");
        wait_flag();
        check(shunt_result, 16'd1000);
        check({3'h0, bus_result}, 16'd2500);
        check(current_result, 16'h0000);
        srd();
        cyc(1);
        check(conversion_ready_flag, 16'h0000);
        wcal(16'd4096);
        settle();
        check(current_result, 16'd1000);
        check(power_result, 16'd500);
        sh = 16'd32000;
        wcal(16'h4000);
        settle();
        check(current_result, 16'd32767);
        check(power_result, 16'd16383);
        $display("test scaling done");
        wcfg(16'h3d4f);
        check(conversion_ready_flag, 16'h0000);
        {n_sh, n_bus} = 64'h0;
        wait_flag();
        check(16'(n_sh), 16'd2);
        check(16'(n_bus), 16'd4);
        wcfg(16'h399c);
        check(conversion_ready_flag, 16'h0001);
        {n_sh, n_bus} = 64'h0;
        cyc(200);
        check(16'(n_sh + n_bus), 16'h0000);
        check(current_result, 16'd32767);
        wcfg(16'h3998);
        check({15'h0, sense_enable}, 16'h0000);
        check({15'h0, conversion_ready_flag}, 16'h0001);
        cyc(50);
        wcfg(16'h399f);
        check(conversion_ready_flag, 16'h0000);
        cyc(990);
        check({15'h0, meas_ready}, 16'h0000);
        check(16'(n_sh), 16'h0000);
        cyc(20);
        check({15'h0, meas_ready}, 16'h0001);
        $display("test modes done");
        wcfg(16'h399b);
        {n_sh, n_bus} = 64'h0;
        convert_n = 1'b0;
        cyc(80);
        convert_n = 1'b1;
        cyc(20);
        check(16'(n_sh + n_bus), 16'h0000);
        convert_n = 1'b0;
        wait_flag();
        cyc(150);
        check(16'(n_sh + n_bus), 16'd2);
        convert_n = 1'b1;
        lat = 8'd60;
        cyc(5);
        convert_n = 1'b0;
        cyc(106);
        check(conversion_ready_flag, 16'h0000);
        convert_n = 1'b1;
        cyc(4);
        convert_n = 1'b0;
        wait_flag();
        cyc(150);
        check(16'(n_sh + n_bus), 16'd4);
        convert_n = 1'b1;
        lat = 8'h02;
        for (int i = 1; i < 4; i++) begin
            m = i[2:0];
            convert_n = 1'b0;
            cyc(5);
            {n_sh, n_bus} = 64'h0;
            wcfg(16'h3998 | {13'h0, m});
            wait_flag();
            cyc(150);
            check(16'(n_sh), {15'h0, m[0]});
            check(16'(n_bus), {15'h0, m[1]});
            convert_n = 1'b1;
            cyc(5);
        end
        for (int i = 5; i < 7; i++) begin
            m = i[2:0];
            wcfg(16'h2198 | {13'h0, m});
            wait_flag();
            {n_sh, n_bus} = 64'h0;
            srd();
            wait_flag();
            check(16'(n_sh), {15'h0, m[0]});
            check(16'(n_bus), {15'h0, m[1]});
            check(shunt_result, 16'd4000);
        end
        $display("test triggers done");
        for (int k = 0; k < 2; k++) begin
            wait_flag();
            wcal(16'h1234);
            if (k == 0) begin
                wcfg(16'h8000);
            end else begin
                gen_call_rst = 1'b1;
                cyc(1);
                gen_call_rst = 1'b0;
            end
            check(cfg_value, 16'h399f);
            check(cal_value, 16'h0000);
            check(conversion_ready_flag, 16'h0000);
            check(shunt_result, 16'h0000);
        end
        $display("test soft reset done");
        test_done();
    end
endmodule : test_shunt_monitor_conversion_control
